// file: dv/viterbi_soft_decoder_tb_top.sv
// self-checking bench: random blocks, decoded words checked against the source bits
`timescale 1ns/100ps
module viterbi_soft_decoder_tb_top;
  import vsd_pkg::*;
  localparam int SUBS = 16;
  localparam int DW = VSD_WORD_W - VSD_K + 1;
  localparam int NST = SUBS * DW, NS = 1 << (VSD_K - 1);
  // design connections, plus the model's go strobe
  logic mclk, rst, start, terminated, busy, done, softValid, softReady, outValid, go;
  logic [VSD_NOUT*VSD_SOFT_W-1:0] softIn;
  logic [DW-1:0] outWord;
  logic [3:0] outIndex;
  // source bits of the block under test
  logic [NST-1:0] dataBits;
  // bookkeeping; expected note is {word, index, done}
  int err_count = 0, checks = 0, seed = 32'h9c7f08ed;
  logic [DW+4:0] expQ [$], e;
  // pacing counters and flags of the watcher
  int pairCnt = 0, lowCnt = 0;
  logic saving = 1'b0, rdyPrev = 1'b0, doneSeen = 1'b0;
  vsd_viterbi_decoder #(.K(VSD_K), .SUBBLOCKS(SUBS), .GENS(VSD_GENS)) u_dut (
    .mclk(mclk), .rst(rst), .start(start), .terminated(terminated), .busy(busy),
    .done(done), .softIn(softIn), .softValid(softValid), .softReady(softReady),
    .outWord(outWord), .outIndex(outIndex), .outValid(outValid));
  vsd_demod_model #(.NST(NST)) u_demod (
    .mclk(mclk), .go(go), .dataBits(dataBits), .softIn(softIn),
    .softValid(softValid), .softReady(softReady));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // one comparison, counted
  task automatic checkEq(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("Counts: checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one block: random data, notes of every word, a refused second start
  task automatic runBlock(input logic term);
    logic [DW-1:0] w;
    int t;
    for (int j = 0; j < NST; j++) begin
      dataBits[j] = 1'($random(seed));
    end
    // terminated blocks carry zero tail bits
    if (term) begin
      dataBits[NST-1 -: VSD_K-1] = '0;
    end
    terminated = term;
    // words come newest sub-block first, oldest bit in the msb
    for (int n = SUBS - 1; n >= 0; n--) begin
      for (int j = 0; j < DW; j++) begin
        w[DW-1-j] = dataBits[n*DW+j];
      end
      expQ.push_back({w, 4'(n), n == 0});
    end
    start = 1'b1;
    go = 1'b1;
    @(posedge mclk);
    #1;
    start = 0;
    go = 0;
    // a start while busy must change nothing
    repeat (40) @(posedge mclk);
    #1;
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 5000) begin
      @(posedge mclk);
      #1;
      t++;
    end
    repeat (2) @(posedge mclk);
    #1;
    checkEq(expQ.size(), 0);
  endtask
  // watcher: sample pacing at the edge, outputs once settled
  always @(posedge mclk) begin
    if (softValid === 1'b1 && softReady === 1'b1) begin
      pairCnt++;
    end
    #1;
    if (busy !== 1'b1) begin
      saving = 1'b0;
      pairCnt = 0;
    end else if (rdyPrev === 1'b1 && softReady === 1'b0) begin
      checkEq(pairCnt, DW);
      pairCnt = 0;
      lowCnt = 1;
      saving = 1'b1;
    end else if (saving && softReady === 1'b0) begin
      lowCnt++;
    end else if (saving && softReady === 1'b1) begin
      checkEq(lowCnt, NS);
      saving = 1'b0;
    end
    rdyPrev = softReady;
    // busy falls on the same edge as done, so it is low the cycle after done
    if (doneSeen) begin
      checkEq(busy, 1'b0);
    end
    doneSeen = 1'b0;
    if (outValid === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("Error at %0t: output word with nothing expected", $time);
      end else begin
        e = expQ.pop_front();
        checkEq(outWord, e[DW+4:5]);
        checkEq(outIndex, e[4:1]);
        checkEq(done, e[0]);
        doneSeen = (done === 1'b1);
      end
    end
  end
  // main sequence: reset, then terminated and open blocks in turn
  initial begin
    rst = 1'b1;
    start = 1'b0;
    terminated = 1'b0;
    go = 1'b0;
    dataBits = '0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    @(posedge mclk);
    #1;
    checkEq({busy, done, softReady, outValid, outIndex, outWord}, 32'h00000000);
    runBlock(1'b1);
    runBlock(1'b0);
    runBlock(1'b1);
    runBlock(1'b0);
    tally_and_finish();
  end
  // hang guard, well beyond four blocks of about 600 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule

// file: dv/vsd_demod_model.sv
// demodulator model: encodes a bit block and offers it as soft sample pairs
`timescale 1ns/100ps
module vsd_demod_model #(
  parameter int NST = 192
) (
  // clock
  input wire logic mclk,
  // block request from the bench
  input wire logic go,
  input wire logic [NST-1:0] dataBits,
  // soft sample stream towards the decoder
  output logic [vsd_pkg::VSD_NOUT*vsd_pkg::VSD_SOFT_W-1:0] softIn,
  output logic softValid,
  input wire logic softReady
);
  import vsd_pkg::*;
  // private random stream for magnitudes and stalls
  int seed = 32'h9c7f08ed;
  // one block: encoder starts in the zero state, pairs handed over whole
  task automatic sendBlock();
    logic [VSD_K-1:0] win;
    logic [VSD_K-2:0] sr;
    logic [VSD_SOFT_W-1:0] smp [VSD_NOUT];
    logic ob;
    int mag;
    #1;
    sr = '0;
    for (int s = 0; s < NST; s++) begin
      win = {sr, dataBits[s]};
      sr = win[VSD_K-2:0];
      for (int j = 0; j < VSD_NOUT; j++) begin
        ob = ^(win & VSD_GENS[j][VSD_K-1:0]);
        mag = 64 + ($random(seed) & 63);
        // a weak wrong sample now and then, still inside FF81..007F
        if ((s % 16) == 5 && j == 0) begin
          smp[j] = ob ? 16'h0010 : 16'hFFF0;
        end else begin
          smp[j] = VSD_SOFT_W'(ob ? -mag : mag);
        end
      end
      // random stalls; released lines show a changing pattern, not old data
      while (($random(seed) & 3) == 0) begin
        softValid = 1'b0;
        softIn = ~softIn;
        @(posedge mclk);
        #1;
      end
      softIn = {smp[1], smp[0]};
      softValid = 1'b1;
      // hold the pair until an edge that samples ready high
      @(posedge mclk);
      while (softReady !== 1'b1) begin
        @(posedge mclk);
      end
      #1;
    end
    softValid = 1'b0;
    softIn = ~softIn;
  endtask
  // idle until the bench asks for a block
  initial begin
    softIn = 32'h00000000;
    softValid = 1'b0;
    forever begin
      @(posedge mclk);
      if (go === 1'b1) begin
        sendBlock();
      end
    end
  end
endmodule

// file: verilog/vsd_acs_stage.sv
// one full trellis stage of add-compare-select, combinational
`timescale 1ns/100ps
module vsd_acs_stage #(
  parameter int K = vsd_pkg::VSD_K,
  parameter int NS = 1 << (K - 1),
  parameter logic [vsd_pkg::VSD_NOUT-1:0][15:0] GENS = vsd_pkg::VSD_GENS
) (
  // soft samples of this stage
  input wire logic [vsd_pkg::VSD_NOUT*vsd_pkg::VSD_SOFT_W-1:0] softIn,
  // old and new metrics / survivors
  input wire logic [NS-1:0][vsd_pkg::VSD_PM_W-1:0] pmIn,
  input wire logic [NS-1:0][vsd_pkg::VSD_WORD_W-1:0] survIn,
  output logic [NS-1:0][vsd_pkg::VSD_PM_W-1:0] pmOut,
  output logic [NS-1:0][vsd_pkg::VSD_WORD_W-1:0] survOut
);
  import vsd_pkg::*;
  localparam int HALF = NS / 2;

  // magnitude for old state j taking input 0
  function automatic logic [VSD_PM_W-1:0] branchMag(input int j);
    logic [15:0] regBits;
    logic [VSD_PM_W-1:0] acc;
    regBits = 16'(j << 1);
    acc = '0;
    for (int i = 0; i < VSD_NOUT; i++) begin
      if (^(GENS[i] & regBits)) begin
        acc = acc - softIn[i*VSD_SOFT_W +: VSD_SOFT_W];
      end else begin
        acc = acc + softIn[i*VSD_SOFT_W +: VSD_SOFT_W];
      end
    end
    return acc;
  endfunction

  // butterfly j: old j, j+HALF feed new 2j, 2j+1
  always_comb begin
    logic [VSD_PM_W-1:0] branchMetricMagnitude, fromLo, fromHi;
    branchMetricMagnitude = '0;
    fromLo = '0;
    fromHi = '0;
    pmOut = pmIn;
    survOut = survIn;
    for (int j = 0; j < HALF; j++) begin
      branchMetricMagnitude = branchMag(j);
      // even target: straight from low, crossed from high
      fromLo = pmIn[j] + branchMetricMagnitude;
      fromHi = pmIn[j+HALF] - branchMetricMagnitude;
      // ties keep the low predecessor
      if (vsdPmGreater(fromHi, fromLo)) begin
        pmOut[2*j] = fromHi;
        survOut[2*j] = {survIn[j+HALF][VSD_WORD_W-2:0], 1'h0};
      end else begin
        pmOut[2*j] = fromLo;
        survOut[2*j] = {survIn[j][VSD_WORD_W-2:0], 1'h0};
      end
      // odd target: signs swap
      fromLo = pmIn[j] - branchMetricMagnitude;
      fromHi = pmIn[j+HALF] + branchMetricMagnitude;
      if (vsdPmGreater(fromHi, fromLo)) begin
        pmOut[2*j+1] = fromHi;
        survOut[2*j+1] = {survIn[j+HALF][VSD_WORD_W-2:0], 1'h1};
      end else begin
        pmOut[2*j+1] = fromLo;
        survOut[2*j+1] = {survIn[j][VSD_WORD_W-2:0], 1'h1};
      end
    end
  end
endmodule

// file: verilog/vsd_mem_if.sv
// survivor memory port bundle
`timescale 1ns/100ps
interface vsd_mem_if #(parameter int AW = 8, parameter int DW = 16);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic rdEn;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport ctrl (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

// file: verilog/vsd_pkg.sv
// constants, types and shared functions of the soft-decision viterbi decoder
// Behaviour
// - trellis starts at the all-zero state
// - one expected output bit per soft sample
// - add soft sample for 0, subtract for 1
// - one branch magnitude serves a whole butterfly
// - straight transitions +magnitude, crossed ones -magnitude
// - new metric is old metric plus branch
// - larger of two incoming metrics survives
// - one metric and survivor per encoder state
// - survivor shifts left, new bit at lsb
// - each survivor held in one 16-bit word
// - K-1 pointer bits, remaining bits carry data
// - sub-block saved every 16-(K-1) stages
// - trace from best state, or zero if terminated
// - terminated blocks end with K-1 zero tails
// - word pointer equals tail of older word
// - words stored in state order, tail = index
// - emit word data, follow pointer to older sub-block
// - repeat down to sub-block 0, 12 bits each
package vsd_pkg;
  localparam int VSD_K = 5;
  localparam int VSD_MIN_K = 3;
  localparam int VSD_MAX_K = 9;
  localparam int VSD_NOUT = 2;
  localparam int VSD_WORD_W = 16;
  localparam int VSD_SOFT_W = 16;
  localparam int VSD_PM_W = 16;
  localparam int VSD_SUBBLOCKS = 16;
  // encoder taps, bit 0 is the newest input bit
  localparam logic [VSD_NOUT-1:0][15:0] VSD_GENS = {16'h001B, 16'h0019};
  localparam logic [VSD_PM_W-1:0] VSD_PM_ZERO = 16'h0000;
  // far below any live path, still inside the modular window
  localparam logic [VSD_PM_W-1:0] VSD_PM_INIT = 16'hE000;
  typedef enum {VSD_IDLE, VSD_ACS, VSD_SAVE, VSD_SEARCH, VSD_TREAD, VSD_TOUT} vsd_state_e;
  // a beats b when the wrapped difference is positive
  function automatic logic vsdPmGreater(input logic [VSD_PM_W-1:0] a,
                                        input logic [VSD_PM_W-1:0] b);
    logic [VSD_PM_W-1:0] diff;
    diff = a - b;
    return !diff[VSD_PM_W-1] && (diff != '0);
  endfunction
endpackage

// file: verilog/vsd_surv_mem.sv
// sub-block survivor store, registered read data
`timescale 1ns/100ps
module vsd_surv_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock
  input wire logic mclk,
  // access port
  vsd_mem_if.mem port
);
  // one word per state per sub-block
  logic [DW-1:0] store [1<<AW];
  logic [DW-1:0] rdData_q;

  // write side, no reset needed on storage
  always_ff @(posedge mclk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
  end

  // read data comes one edge after the request
  always_ff @(posedge mclk) begin
    if (port.rdEn) begin
      rdData_q <= store[port.rdAddr];
    end
  end

  assign port.rdData = rdData_q;
endmodule

// file: verilog/vsd_viterbi_decoder.sv
// soft-decision viterbi decoder top: stage engine, sub-block save, traceback
`timescale 1ns/100ps
module vsd_viterbi_decoder #(
  parameter int K = vsd_pkg::VSD_K,
  parameter int SUBBLOCKS = vsd_pkg::VSD_SUBBLOCKS,
  parameter logic [vsd_pkg::VSD_NOUT-1:0][15:0] GENS = vsd_pkg::VSD_GENS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // block control
  input wire logic start,
  input wire logic terminated,
  output wire logic busy,
  output wire logic done,
  // soft sample stream
  input wire logic [vsd_pkg::VSD_NOUT*vsd_pkg::VSD_SOFT_W-1:0] softIn,
  input wire logic softValid,
  output wire logic softReady,
  // decoded stream, one sub-block per word
  output wire logic [vsd_pkg::VSD_WORD_W-K:0] outWord,
  output wire logic [$clog2(SUBBLOCKS)-1:0] outIndex,
  output wire logic outValid
);
  import vsd_pkg::*;

  // derived geometry
  localparam int NS = 1 << (K - 1);
  localparam int HALF = NS / 2;
  localparam int PTR_W = K - 1;
  localparam int DATA_BITS = VSD_WORD_W - PTR_W;
  localparam int SUB_W = $clog2(SUBBLOCKS);
  localparam int ADDR_W = SUB_W + PTR_W;
  localparam int CNT_W = $clog2(DATA_BITS);
  // pointer field sits at the top of each word
  localparam int PTR_TOP = VSD_WORD_W - 1;
  localparam logic [CNT_W-1:0] STAGE_LAST = CNT_W'(DATA_BITS - 1);
  localparam logic [PTR_W-1:0] STATE_LAST = PTR_W'(NS - 1);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SUBBLOCKS - 1);

  // the butterfly sign trick needs taps at both ends of every generator
  function automatic logic tapsOk();
    logic ok;
    ok = 1'h1;
    for (int i = 0; i < VSD_NOUT; i++) begin
      ok = ok && GENS[i][0] && GENS[i][K-1];
    end
    return ok;
  endfunction

  // refuse geometries the logic cannot serve
  if (K < VSD_MIN_K || K > VSD_MAX_K || SUBBLOCKS < 2 ||
      (1 << SUB_W) != SUBBLOCKS || !tapsOk()) begin : g_badParam
    $error("vsd_viterbi_decoder: unsupported K, SUBBLOCKS or taps");
  end

  // control state
  vsd_state_e state_q, state_d;
  // stages done in the current sub-block
  logic [CNT_W-1:0] stageCnt_q;
  // word index while saving
  logic [PTR_W-1:0] saveIdx_q;
  // sub-block number, counts up while saving, down while tracing
  logic [SUB_W-1:0] subCnt_q;
  // traceback pointer into the current sub-block
  logic [PTR_W-1:0] ptr_q;
  // one metric and one survivor per state
  logic [NS-1:0][VSD_PM_W-1:0] pm_q, pmNext;
  logic [NS-1:0][VSD_WORD_W-1:0] surv_q, survNext;
  // best final state and its metric
  logic [PTR_W-1:0] bestState;
  logic [VSD_PM_W-1:0] bestPm;
  // registered outputs
  logic busy_q;
  logic done_q;
  logic softReady_q;
  logic [DATA_BITS-1:0] outWord_q;
  logic [SUB_W-1:0] outIndex_q;
  logic outValid_q;
  // a sample pair is taken this edge
  logic accept;

  // survivor memory bundle
  vsd_mem_if #(.AW(ADDR_W), .DW(VSD_WORD_W)) memBus ();

  vsd_surv_mem #(
    .AW(ADDR_W),
    .DW(VSD_WORD_W)
  ) u_mem (
    .mclk(mclk),
    .port(memBus.mem)
  );

  vsd_acs_stage #(
    .K(K),
    .NS(NS),
    .GENS(GENS)
  ) u_acs (
    .softIn(softIn),
    .pmIn(pm_q),
    .survIn(surv_q),
    .pmOut(pmNext),
    .survOut(survNext)
  );

  // ready is a flop, so a sample only lands in the stage state
  assign accept = softValid && softReady_q;

  // next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      VSD_IDLE: begin
        // start from the zero state
        if (start) begin
          state_d = VSD_ACS;
        end
      end
      VSD_ACS: begin
        // save before the words would overflow
        if (accept && stageCnt_q == STAGE_LAST) begin
          state_d = VSD_SAVE;
        end
      end
      VSD_SAVE: begin
        // last word written: next sub-block or end of block
        if (saveIdx_q == STATE_LAST) begin
          state_d = (subCnt_q == SUB_LAST) ? VSD_SEARCH : VSD_ACS;
        end
      end
      VSD_SEARCH: begin
        state_d = VSD_TREAD;
      end
      VSD_TREAD: begin
        state_d = VSD_TOUT;
      end
      VSD_TOUT: begin
        // stop once sub-block 0 has been emitted
        state_d = (subCnt_q == '0) ? VSD_IDLE : VSD_TREAD;
      end
      default: begin
        state_d = VSD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= VSD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // path metrics: seeded at start, updated per accepted stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      pm_q <= '0;
    end else if (state_q == VSD_IDLE && start) begin
      // only state 0 is a live start
      for (int s = 0; s < NS; s++) begin
        pm_q[s] <= (s == 0) ? VSD_PM_ZERO : VSD_PM_INIT;
      end
    end else if (accept) begin
      // add-compare-select result
      pm_q <= pmNext;
    end
  end

  // survivor words shift on every accepted stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      surv_q <= '0;
    end else if (state_q == VSD_IDLE && start) begin
      surv_q <= '0;
    end else if (accept) begin
      // lsb takes the state's input bit
      surv_q <= survNext;
    end
  end

  // stage counter within a sub-block
  always_ff @(posedge mclk) begin
    if (rst) begin
      stageCnt_q <= '0;
    end else if (state_q == VSD_IDLE && start) begin
      stageCnt_q <= '0;
    end else if (accept) begin
      // period of 16-(K-1) stages
      stageCnt_q <= (stageCnt_q == STAGE_LAST) ? '0 : stageCnt_q + 1'h1;
    end
  end

  // save index walks all states in order
  always_ff @(posedge mclk) begin
    if (rst) begin
      saveIdx_q <= '0;
    end else if (state_q == VSD_SAVE) begin
      // wraps to zero after the last state
      saveIdx_q <= saveIdx_q + 1'h1;
    end
  end

  // sub-block counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      subCnt_q <= '0;
    end else if (state_q == VSD_IDLE && start) begin
      subCnt_q <= '0;
    end else if (state_q == VSD_SAVE && saveIdx_q == STATE_LAST &&
                 subCnt_q != SUB_LAST) begin
      subCnt_q <= subCnt_q + 1'h1;
    end else if (state_q == VSD_TOUT && subCnt_q != '0) begin
      // traceback runs toward sub-block 0
      subCnt_q <= subCnt_q - 1'h1;
    end
  end

  // largest final metric, lowest state wins a tie
  always_comb begin
    bestState = '0;
    bestPm = pm_q[0];
    for (int s = 1; s < NS; s++) begin
      if (vsdPmGreater(pm_q[s], bestPm)) begin
        bestPm = pm_q[s];
        bestState = PTR_W'(s);
      end
    end
  end

  // traceback pointer
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (state_q == VSD_SEARCH) begin
      // tails force the zero state when terminated
      ptr_q <= terminated ? '0 : bestState;
    end else if (state_q == VSD_TOUT) begin
      // leading bits point into the older sub-block
      ptr_q <= memBus.rdData[PTR_TOP -: PTR_W];
    end
  end

  // memory requests, address is {sub-block, state}
  always_comb begin
    memBus.wrEn = (state_q == VSD_SAVE);
    memBus.wrAddr = {subCnt_q, saveIdx_q};
    memBus.wrData = surv_q[saveIdx_q];
    memBus.rdEn = (state_q == VSD_TREAD);
    memBus.rdAddr = {subCnt_q, ptr_q};
  end

  // decoded word out, newest sub-block first
  always_ff @(posedge mclk) begin
    if (rst) begin
      outValid_q <= 1'h0;
      outWord_q <= '0;
      outIndex_q <= '0;
    end else begin
      outValid_q <= (state_q == VSD_TOUT);
      if (state_q == VSD_TOUT) begin
        // trailing data bits of the word
        outWord_q <= memBus.rdData[DATA_BITS-1:0];
        outIndex_q <= subCnt_q;
      end
    end
  end

  // done pulse rides with the sub-block 0 word
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'h0;
    end else begin
      done_q <= (state_q == VSD_TOUT && subCnt_q == '0);
    end
  end

  // ready and busy look one state ahead so they stay flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      softReady_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      softReady_q <= (state_d == VSD_ACS);
      busy_q <= (state_d != VSD_IDLE);
    end
  end

  // ports
  assign busy = busy_q;
  assign done = done_q;
  assign softReady = softReady_q;
  assign outWord = outWord_q;
  assign outIndex = outIndex_q;
  assign outValid = outValid_q;

  // checking helpers: expected metrics of new states 0 and 1
  logic [VSD_PM_W-1:0] chkMag0, chkPm0, chkPm1;
  always_comb begin
    chkMag0 = '0;
    // old state 0 with input 0 expects all-zero outputs
    for (int i = 0; i < VSD_NOUT; i++) begin
      chkMag0 = chkMag0 + softIn[i*VSD_SOFT_W +: VSD_SOFT_W];
    end
    chkPm0 = vsdPmGreater(pm_q[HALF] - chkMag0, pm_q[0] + chkMag0) ?
             pm_q[HALF] - chkMag0 : pm_q[0] + chkMag0;
    chkPm1 = vsdPmGreater(pm_q[HALF] + chkMag0, pm_q[0] - chkMag0) ?
             pm_q[HALF] + chkMag0 : pm_q[0] - chkMag0;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // one traceback step
  sequence sTraceStep;
    state_q == VSD_TOUT && subCnt_q != '0;
  endsequence

  sequence sNextRead;
    state_q == VSD_TREAD ##1 state_q == VSD_TOUT;
  endsequence

  a_start_zero: assert property (
    state_q == VSD_IDLE && start |=>
      pm_q[0] == VSD_PM_ZERO && pm_q[1] == VSD_PM_INIT && surv_q == '0)
    else $error("start did not seed the zero state");

  a_acs_even: assert property (
    accept |=> pm_q[0] == $past(chkPm0))
    else $error("state 0 metric wrong after a stage");

  a_acs_odd: assert property (
    accept |=> pm_q[1] == $past(chkPm1))
    else $error("state 1 metric sign wrong");

  a_surv_lsb: assert property (
    accept |=> surv_q[0][0] == 1'h0 && surv_q[1][0] == 1'h1)
    else $error("survivor lsb does not follow the state");

  a_save_spacing: assert property (
    $rose(state_q == VSD_SAVE) |-> $past(stageCnt_q) == STAGE_LAST &&
      $past(accept))
    else $error("sub-block save off its period");

  a_save_order: assert property (
    memBus.wrEn |-> memBus.wrData[PTR_W-1:0] == memBus.wrAddr[PTR_W-1:0])
    else $error("saved word tail differs from its index");

  a_trace_step: assert property (
    sTraceStep |=> sNextRead and
      (ptr_q == $past(memBus.rdData[PTR_TOP -: PTR_W]) &&
       outWord_q == $past(memBus.rdData[DATA_BITS-1:0])))
    else $error("traceback step did not follow the pointer");

  a_term_zero: assert property (
    state_q == VSD_SEARCH |=>
      ptr_q == ($past(terminated) ? '0 : $past(bestState)))
    else $error("traceback start state wrong");

  a_done_last: assert property (
    outValid_q && outIndex_q == '0 |-> done_q ##1 !done_q && !busy_q)
    else $error("done not tied to the sub-block 0 word");

  a_ready_acs: assert property (
    softReady_q |-> state_q == VSD_ACS)
    else $error("ready outside the stage state");
endmodule
